// file: rtl/tss_pkg.sv
package tss_pkg;

    // register byte addresses
    localparam logic [7:0] TSS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] TSS_ADDR_CMD = 8'h04;
    localparam logic [7:0] TSS_ADDR_STAT = 8'h08;
    localparam logic [7:0] TSS_ADDR_SRC = 8'h0C;
    localparam logic [7:0] TSS_ADDR_ESR = 8'h10;
    localparam logic [7:0] TSS_ADDR_OBUF = 8'h14;

    // control register fields
    localparam int TSS_CTRL_SRC_LSB = 0;
    localparam int TSS_CTRL_LINE_LSB = 2;
    localparam int TSS_CTRL_SLOPE_BIT = 5;
    localparam int TSS_CTRL_MODE_LSB = 6;
    localparam int TSS_CTRL_EN_BIT = 8;

    // command register bits, each a one-shot strobe
    localparam int TSS_CMD_TRG_BIT = 0;
    localparam int TSS_CMD_GET_BIT = 1;
    localparam int TSS_CMD_WAVEFORM_COMMAND_A_BIT = 2;
    localparam int TSS_CMD_WAIT_BIT = 3;
    localparam int TSS_CMD_OPC_BIT = 4;
    localparam int TSS_CMD_OPCQ_BIT = 5;

    // status register bits
    localparam int TSS_STAT_ARMED_BIT = 0;
    localparam int TSS_STAT_BUSY_BIT = 1;
    localparam int TSS_STAT_GATE_BIT = 2;
    localparam int TSS_STAT_STALL_BIT = 3;

    // output buffer layout
    localparam int TSS_OBUF_VALID_BIT = 8;
    localparam logic [7:0] TSS_OPCQ_ANSWER = 8'h01;

    // trigger inputs: index 0 is the connector, 1..8 backplane lines
    localparam int TSS_BP_LINES = 8;

    // least pulse period on the connector, kept by the driving party
    localparam int TSS_CLK_MHZ = 25;
    localparam int TSS_EXT_PERIOD_NS = 2000;
    localparam int TSS_EXT_PERIOD_CYC = (TSS_EXT_PERIOD_NS * TSS_CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        SRC_ALWAYS = 2'b00,
        SRC_EXT = 2'b01,
        SRC_BUS = 2'b10,
        SRC_BPL = 2'b11
    } tss_src_e;

    typedef enum logic [1:0] {
        MODE_BURST = 2'b00,
        MODE_SWEEP = 2'b01,
        MODE_GATED = 2'b10,
        MODE_FSK = 2'b11
    } tss_mode_e;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_ARMED = 2'b01,
        RUN_BUSY = 2'b10
    } tss_run_e;

    // values after reset
    localparam tss_src_e TSS_SRC_RST = SRC_ALWAYS;
    localparam logic TSS_SLOPE_RST = 1'b0;

endpackage

// file: rtl/tss_top.sv
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - exactly one trigger source active: bus, connector, internal, or one of eight lines.
// - reset selects the internal always-present source.
// - source selection is held in plain flip-flops, lost on power loss.
// - internal source with burst or sweep enabled restarts continuously.
// - the waveform_command_a command forces the internal source.
// - connector source starts one burst or sweep per qualifying edge.
// - gated burst and FSK follow the connector level; slope ignored.
// - backplane lines act like the connector with inverted polarity.
// - bus trigger starts one counted burst or sweep; no gated effect.
// - group execute trigger acts exactly like a bus trigger.
// - wait command holds further commands until the running operation ends.
// - operation-complete query answers 1 once the operation has finished.
// - operation-complete command sets event bit 0 when the operation finishes.
// - FSK with internal or bus source gates from the connector.
// - a source query returns a code of the present selection.
// - positive slope: connector rising, lines falling; negative reverses both.
module tss_top import tss_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic ext_trig_i,
    input wire logic [TSS_BP_LINES-1:0] bp_trig_i,
    input wire logic op_done_i,
    output logic start_o,
    output logic gate_o,
    output logic run_busy_o,
    output logic cmd_stall_o
);

    tss_trig_if #(.W(TSS_BP_LINES + 1)) trig ();

    tss_trig_cond #(.W(TSS_BP_LINES + 1)) u_cond (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i({bp_trig_i, ext_trig_i}),
        .trig(trig.cond)
    );

    // pick the qualifying edge for an input of given sense
    function automatic logic pick_edge(input logic rise, input logic fall, input logic want_rise);
        pick_edge = want_rise ? rise : fall;
    endfunction

    ////////////////////////////////////////////////////////////////
    // configuration state
    tss_src_e src_q, src_d;
    tss_mode_e mode_q, mode_d;
    logic [2:0] line_q, line_d;
    logic slope_neg_q, slope_neg_d;
    logic en_q, en_d;

    logic wr_ctrl, wr_cmd, cmd_ok;
    logic bus_trg, waveform_command_a_cmd, wait_cmd, opc_cmd, opcq_cmd;

    // decode of register writes; commands dropped while held
    always_comb begin
        wr_ctrl = wr_i && (addr_i == TSS_ADDR_CTRL);
        wr_cmd = wr_i && (addr_i == TSS_ADDR_CMD);
        cmd_ok = wr_cmd && !cmd_stall_o;
        bus_trg = cmd_ok && (wdata_i[TSS_CMD_TRG_BIT] || wdata_i[TSS_CMD_GET_BIT]);
        waveform_command_a_cmd = cmd_ok && wdata_i[TSS_CMD_WAVEFORM_COMMAND_A_BIT];
        wait_cmd = cmd_ok && wdata_i[TSS_CMD_WAIT_BIT];
        opc_cmd = cmd_ok && wdata_i[TSS_CMD_OPC_BIT];
        opcq_cmd = cmd_ok && wdata_i[TSS_CMD_OPCQ_BIT];
    end

    // next configuration; waveform_command_a overrides a same-cycle control write
    always_comb begin
        src_d = src_q;
        mode_d = mode_q;
        line_d = line_q;
        slope_neg_d = slope_neg_q;
        en_d = en_q;
        if (wr_ctrl) begin
            src_d = tss_src_e'(wdata_i[TSS_CTRL_SRC_LSB +: 2]);
            line_d = wdata_i[TSS_CTRL_LINE_LSB +: 3];
            slope_neg_d = wdata_i[TSS_CTRL_SLOPE_BIT];
            mode_d = tss_mode_e'(wdata_i[TSS_CTRL_MODE_LSB +: 2]);
            en_d = wdata_i[TSS_CTRL_EN_BIT];
        end
        if (waveform_command_a_cmd) begin
            src_d = SRC_ALWAYS;
        end
    end

    // volatile configuration flip-flops
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            src_q <= TSS_SRC_RST;
            mode_q <= MODE_BURST;
            line_q <= 3'h0;
            slope_neg_q <= TSS_SLOPE_RST;
            en_q <= 1'b0;
        end else begin
            src_q <= src_d;
            mode_q <= mode_d;
            line_q <= line_d;
            slope_neg_q <= slope_neg_d;
            en_q <= en_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // trigger selection
    logic ext_lvl, bp_lvl, ext_edge, bp_edge, counted, trig_hit;

    always_comb begin
        ext_lvl = trig.lvl[0];
        bp_lvl = trig.lvl[line_q + 4'h1];
        ext_edge = pick_edge(trig.rise[0], trig.fall[0], !slope_neg_q);
        bp_edge = pick_edge(trig.rise[line_q + 4'h1], trig.fall[line_q + 4'h1], slope_neg_q);
        counted = en_q && (mode_q == MODE_BURST || mode_q == MODE_SWEEP);
        case (src_q)
            SRC_ALWAYS: trig_hit = 1'b1;
            SRC_EXT: trig_hit = ext_edge;
            SRC_BUS: trig_hit = bus_trg;
            SRC_BPL: trig_hit = bp_edge;
            default: trig_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // run sequencer
    tss_run_e state_q, state_d;
    logic start_d, busy_d;

    // arm, fire on a qualifying trigger, wait for the engine to finish
    always_comb begin
        state_d = state_q;
        start_d = 1'b0;
        case (state_q)
            RUN_IDLE: begin
                if (counted) begin
                    state_d = RUN_ARMED;
                end
            end
            RUN_ARMED: begin
                if (!counted) begin
                    state_d = RUN_IDLE;
                end else if (trig_hit) begin
                    state_d = RUN_BUSY;
                    start_d = 1'b1;
                end
            end
            RUN_BUSY: begin
                if (op_done_i) begin
                    state_d = counted ? RUN_ARMED : RUN_IDLE;
                end
            end
            default: state_d = RUN_IDLE;
        endcase
        busy_d = (state_d == RUN_BUSY);
    end

    // sequencer flip-flops
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= RUN_IDLE;
            start_o <= 1'b0;
            run_busy_o <= 1'b0;
        end else begin
            state_q <= state_d;
            start_o <= start_d;
            run_busy_o <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // gating for gated burst and FSK, slope plays no part
    logic gate_d;

    always_comb begin
        gate_d = 1'b0;
        if (en_q && mode_q == MODE_FSK) begin
            gate_d = (src_q == SRC_BPL) ? !bp_lvl : ext_lvl;
        end else if (en_q && mode_q == MODE_GATED) begin
            case (src_q)
                SRC_EXT: gate_d = ext_lvl;
                SRC_BPL: gate_d = !bp_lvl;
                SRC_ALWAYS: gate_d = 1'b1;
                SRC_BUS: gate_d = 1'b0;
                default: gate_d = 1'b0;
            endcase
        end
    end

    // gate flip-flop
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            gate_o <= 1'b0;
        end else begin
            gate_o <= gate_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // wait and operation-complete synchronisation
    logic opc_pend_q, opc_pend_d, opcq_pend_q, opcq_pend_d;
    logic esr_opc_q, esr_opc_d, obuf_vld_q, obuf_vld_d, stall_d;
    logic rd_esr, rd_obuf, done_now;

    // pending requests resolve once nothing runs; set beats read-clear
    always_comb begin
        rd_esr = rd_i && (addr_i == TSS_ADDR_ESR);
        rd_obuf = rd_i && (addr_i == TSS_ADDR_OBUF);
        done_now = (state_q != RUN_BUSY) && !start_o;
        stall_d = cmd_stall_o;
        if (wait_cmd && (state_q == RUN_BUSY || start_d)) begin
            stall_d = 1'b1;
        end else if (state_q != RUN_BUSY) begin
            stall_d = 1'b0;
        end
        opc_pend_d = (opc_pend_q || opc_cmd) && !done_now;
        opcq_pend_d = (opcq_pend_q || opcq_cmd) && !done_now;
        esr_opc_d = esr_opc_q && !rd_esr;
        if ((opc_pend_q || opc_cmd) && done_now) begin
            esr_opc_d = 1'b1;
        end
        obuf_vld_d = obuf_vld_q && !rd_obuf;
        if ((opcq_pend_q || opcq_cmd) && done_now) begin
            obuf_vld_d = 1'b1;
        end
    end

    // synchronisation flip-flops
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cmd_stall_o <= 1'b0;
            opc_pend_q <= 1'b0;
            opcq_pend_q <= 1'b0;
            esr_opc_q <= 1'b0;
            obuf_vld_q <= 1'b0;
        end else begin
            cmd_stall_o <= stall_d;
            opc_pend_q <= opc_pend_d;
            opcq_pend_q <= opcq_pend_d;
            esr_opc_q <= esr_opc_d;
            obuf_vld_q <= obuf_vld_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // register read port, data valid only in the cycle after the strobe
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_i) begin
            case (addr_i)
                TSS_ADDR_CTRL: begin
                    rdata_d[TSS_CTRL_SRC_LSB +: 2] = src_q;
                    rdata_d[TSS_CTRL_LINE_LSB +: 3] = line_q;
                    rdata_d[TSS_CTRL_SLOPE_BIT] = slope_neg_q;
                    rdata_d[TSS_CTRL_MODE_LSB +: 2] = mode_q;
                    rdata_d[TSS_CTRL_EN_BIT] = en_q;
                end
                TSS_ADDR_STAT: begin
                    rdata_d[TSS_STAT_ARMED_BIT] = (state_q == RUN_ARMED);
                    rdata_d[TSS_STAT_BUSY_BIT] = run_busy_o;
                    rdata_d[TSS_STAT_GATE_BIT] = gate_o;
                    rdata_d[TSS_STAT_STALL_BIT] = cmd_stall_o;
                end
                TSS_ADDR_SRC: rdata_d[1:0] = src_q;
                TSS_ADDR_ESR: rdata_d[0] = esr_opc_q;
                TSS_ADDR_OBUF: begin
                    rdata_d[TSS_OBUF_VALID_BIT] = obuf_vld_q;
                    rdata_d[7:0] = obuf_vld_q ? TSS_OPCQ_ANSWER : 8'h00;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // read data register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    a_reset_internal: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $past(rst_i) |-> src_q == SRC_ALWAYS)
        else $error("source not internal after reset");

    a_waveform_command_a_forces: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        waveform_command_a_cmd |=> src_q == SRC_ALWAYS)
        else $error("waveform_command_a did not select internal source");

    a_always_restart: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_q == RUN_ARMED && src_q == SRC_ALWAYS && counted) |=> start_o ##1 run_busy_o)
        else $error("internal source did not restart at once");

    a_bus_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_q == RUN_ARMED && counted && src_q == SRC_BUS && bus_trg) |=> start_o)
        else $error("bus trigger did not start a run");

    a_ext_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_q == RUN_ARMED && counted && src_q == SRC_EXT && ext_edge) |=> start_o)
        else $error("connector edge did not start a run");

    a_no_idle_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_q != RUN_ARMED) |=> !start_o)
        else $error("start without an armed sequencer");

    a_bp_inverted: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (en_q && (mode_q == MODE_GATED || mode_q == MODE_FSK) && src_q == SRC_BPL) |=> gate_o == !$past(bp_lvl))
        else $error("backplane gate not inverted");

    a_fsk_connector: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (en_q && mode_q == MODE_FSK && (src_q == SRC_ALWAYS || src_q == SRC_BUS)) |=> gate_o == $past(ext_lvl))
        else $error("fsk gate not from connector");

    a_wait_release: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cmd_stall_o && state_q != RUN_BUSY) |=> !cmd_stall_o)
        else $error("wait hold outlived the run");

    a_opc_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (opc_pend_q && done_now) |=> esr_opc_q)
        else $error("operation-complete bit not set");

    a_opcq_answer: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(obuf_vld_q) |-> $past(done_now))
        else $error("query answered while still pending");

    c_ext_run: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        src_q == SRC_EXT && start_o ##[1:50] op_done_i);
    c_bus_wait: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        cmd_stall_o ##[1:50] !cmd_stall_o);
    c_opc_set: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(esr_opc_q));
    c_fsk_gate: cover property (@(posedge clk_sys_i) disable iff (rst_i) mode_q == MODE_FSK && $rose(gate_o));

endmodule // tss_top

// file: rtl/tss_trig_cond.sv
`timescale 1ns/1ps
module tss_trig_cond import tss_pkg::*; #(
    parameter int W = 9
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    tss_trig_if.cond trig
);

    logic [W-1:0] sync1_q, sync2_q, lvl_q, rise_q, fall_q;
    logic [W-1:0] lvl_d, rise_d, fall_d;

    // idle pin levels: bit 0 idles low, the ground-true lines idle high, so reset shows no false edge
    localparam logic [W-1:0] IDLE_LVL = ~W'(1);

    initial begin
        if (W < 1) begin
            $error("tss_trig_cond: W must be at least 1");
        end
    end

    ////////////////////////////////////////////////////////////////
    // edge detection after the two-stage synchroniser
    always_comb begin
        lvl_d = sync2_q;
        rise_d = sync2_q & ~lvl_q;
        fall_d = ~sync2_q & lvl_q;
    end

    // synchroniser and edge registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync1_q <= IDLE_LVL;
            sync2_q <= IDLE_LVL;
            lvl_q <= IDLE_LVL;
            rise_q <= '0;
            fall_q <= '0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            lvl_q <= lvl_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign trig.lvl = lvl_q;
    assign trig.rise = rise_q;
    assign trig.fall = fall_q;

    ////////////////////////////////////////////////////////////////
    // checks on the edge pulses
    a_edge_single: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rise_q[0] |=> !rise_q[0])
        else $error("edge pulse lasted more than one cycle");

endmodule // tss_trig_cond

// file: rtl/tss_trig_if.sv
`timescale 1ns/1ps
interface tss_trig_if #(parameter int W = 9);
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport cond (output lvl, output rise, output fall);
    modport user (input lvl, input rise, input fall);
endinterface

// file: testbench/trigger_source_select_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module trigger_source_select_tb import tss_pkg::*;;
    logic clk_sys_i;
    logic rst_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [31:0] rdata_o;
    logic ext_trig_i;
    logic [TSS_BP_LINES-1:0] bp_trig_i;
    logic op_done_i;
    logic start_o;
    logic gate_o;
    logic run_busy_o;
    logic cmd_stall_o;
    logic [8:0] trig_lvl;
    int err_total;
    int n_compared;
    int n_start;
    int s0;

    tss_top i_tss_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_trig_i(ext_trig_i), .bp_trig_i(bp_trig_i),
        .op_done_i(op_done_i), .start_o(start_o), .gate_o(gate_o), .run_busy_o(run_busy_o),
        .cmd_stall_o(cmd_stall_o));
    tss_trig_src_model i_tss_trig_src_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .lvl_i(trig_lvl),
        .start_i(start_o), .ext_trig_o(ext_trig_i), .bp_trig_o(bp_trig_i), .op_done_o(op_done_i));

    //////////////////////////////////////////////////////////////////////
    // clock and start counter
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (start_o === 1'b1) n_start++;
    end

    //////////////////////////////////////////////////////////////////////
    // bus tasks
    // idle cycles release both strobes; writes leave wr_i up so back-to-back writes never toggle it
    task automatic wait_cyc(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        addr_i <= a;
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        `CHK("rdata", e, rdata_o)
    endtask
    task automatic summarize;
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_total++;
        summarize();
    end

    //////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        rst_i = 1'b1;
        addr_i = 8'h00;
        wdata_i = 32'h0000_0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        trig_lvl = 9'h000;
        err_total = 0;
        n_compared = 0;
        n_start = 0;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        // reset state and refused places
        rd(TSS_ADDR_CTRL, 32'h0000_0000);
        rd(TSS_ADDR_SRC, 32'h0000_0000);
        rd(TSS_ADDR_STAT, 32'h0000_0000);
        rd(TSS_ADDR_CMD, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000);
        rd(TSS_ADDR_CTRL, 32'h0000_0000);
        // internal source runs without any trigger
        s0 = n_start;
        wr(TSS_ADDR_CTRL, 32'h0000_0100);
        wait_cyc(40);
        `CHK("always runs", 1'b1, (n_start - s0) > 3)
        // bus trigger, wait hold, second trigger dropped
        wr(TSS_ADDR_CTRL, 32'h0000_0102);
        wait_cyc(12);
        rd(TSS_ADDR_SRC, 32'h0000_0002);
        s0 = n_start;
        wr(TSS_ADDR_CMD, 32'h0000_0001);
        #1;
        `CHK("bus start", 1'b1, start_o)
        wr(TSS_ADDR_CMD, 32'h0000_0008);
        wr(TSS_ADDR_CMD, 32'h0000_0001);
        #1;
        `CHK("stall", 1'b1, cmd_stall_o)
        `CHK("busy", 1'b1, run_busy_o)
        wait_cyc(14);
        `CHK("one run", 1, n_start - s0)
        `CHK("stall off", 1'b0, cmd_stall_o)
        // group execute trigger
        wr(TSS_ADDR_CMD, 32'h0000_0002);
        #1;
        `CHK("get start", 1'b1, start_o)
        wait_cyc(14);
        // operation complete, event bit and output buffer
        wr(TSS_ADDR_CMD, 32'h0000_0001);
        wr(TSS_ADDR_CMD, 32'h0000_0010);
        wr(TSS_ADDR_CMD, 32'h0000_0020);
        rd(TSS_ADDR_ESR, 32'h0000_0000);
        rd(TSS_ADDR_OBUF, 32'h0000_0000);
        wait_cyc(14);
        rd(TSS_ADDR_ESR, 32'h0000_0001);
        rd(TSS_ADDR_OBUF, 32'h0000_0101);
        rd(TSS_ADDR_ESR, 32'h0000_0000);
        // waveform_command_a forces the internal source
        wr(TSS_ADDR_CMD, 32'h0000_0004);
        rd(TSS_ADDR_SRC, 32'h0000_0000);
        wr(TSS_ADDR_CTRL, 32'h0000_0000);
        wait_cyc(14);
        // connector edges, both slopes
        wr(TSS_ADDR_CTRL, 32'h0000_0101);
        rd(TSS_ADDR_SRC, 32'h0000_0001);
        s0 = n_start;
        trig_lvl <= 9'h001;
        wait_cyc(40);
        `CHK("ext rise", 1, n_start - s0)
        trig_lvl <= 9'h000;
        wait_cyc(40);
        `CHK("ext fall pos", 1, n_start - s0)
        wr(TSS_ADDR_CTRL, 32'h0000_0121);
        trig_lvl <= 9'h001;
        wait_cyc(40);
        trig_lvl <= 9'h000;
        wait_cyc(40);
        `CHK("ext fall neg", 2, n_start - s0)
        // backplane line 3 only, ground-true
        wr(TSS_ADDR_CTRL, 32'h0000_010F);
        s0 = n_start;
        trig_lvl <= 9'h010;
        wait_cyc(40);
        `CHK("line 3", 1, n_start - s0)
        trig_lvl <= 9'h014;
        wait_cyc(40);
        trig_lvl <= 9'h000;
        wait_cyc(40);
        `CHK("other line", 1, n_start - s0)
        // disabled: edges dropped
        wr(TSS_ADDR_CTRL, 32'h0000_0001);
        s0 = n_start;
        trig_lvl <= 9'h001;
        wait_cyc(40);
        trig_lvl <= 9'h000;
        wait_cyc(40);
        `CHK("disabled", 0, n_start - s0)
        // gated burst follows the level, slope ignored
        wr(TSS_ADDR_CTRL, 32'h0000_0181);
        trig_lvl <= 9'h001;
        wait_cyc(40);
        `CHK("gate ext", 1'b1, gate_o)
        wr(TSS_ADDR_CTRL, 32'h0000_01A1);
        wait_cyc(4);
        `CHK("gate neg", 1'b1, gate_o)
        trig_lvl <= 9'h000;
        wait_cyc(40);
        `CHK("gate low", 1'b0, gate_o)
        // bus trigger has no effect on gated burst
        wr(TSS_ADDR_CTRL, 32'h0000_0182);
        s0 = n_start;
        wr(TSS_ADDR_CMD, 32'h0000_0001);
        wait_cyc(10);
        `CHK("gated bus", 0, n_start - s0)
        // fsk from internal source gates from connector
        wr(TSS_ADDR_CTRL, 32'h0000_01C0);
        trig_lvl <= 9'h001;
        wait_cyc(40);
        `CHK("fsk always", 1'b1, gate_o)
        trig_lvl <= 9'h000;
        wait_cyc(40);
        `CHK("fsk always low", 1'b0, gate_o)
        // fsk from backplane line 0
        wr(TSS_ADDR_CTRL, 32'h0000_01C3);
        trig_lvl <= 9'h002;
        wait_cyc(40);
        `CHK("fsk line", 1'b1, gate_o)
        // sweep from the bus, armed then busy in the status word
        wr(TSS_ADDR_CTRL, 32'h0000_0142);
        wait_cyc(2);
        rd(TSS_ADDR_STAT, 32'h0000_0001);
        wr(TSS_ADDR_CMD, 32'h0000_0001);
        #1;
        `CHK("sweep start", 1'b1, start_o)
        rd(TSS_ADDR_STAT, 32'h0000_0002);
        summarize();
    end
endmodule // trigger_source_select_tb

// file: testbench/tss_trig_src_model.sv
`timescale 1ns/1ps
// far side: connector and backplane drivers plus the waveform engine's done pulse
module tss_trig_src_model import tss_pkg::*; #(
    parameter int HOLD = TSS_EXT_PERIOD_CYC / 2 + 1,
    parameter int DONE_DLY = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [8:0] lvl_i,
    input wire logic start_i,
    output logic ext_trig_o,
    output logic [TSS_BP_LINES-1:0] bp_trig_o,
    output logic op_done_o
);
    logic [8:0] cur_q;
    int hold_q;
    int dcnt_q;
    //////////////////////////////////////////////////////////////////////
    // level changes spaced so a full pulse never beats the least period
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cur_q <= '0;
            hold_q <= 0;
        end else if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end else if (lvl_i != cur_q) begin
            cur_q <= lvl_i;
            hold_q <= HOLD;
        end
    end
    assign ext_trig_o = cur_q[0];
    assign bp_trig_o = ~cur_q[8:1]; // ground-true lines
    //////////////////////////////////////////////////////////////////////
    // engine: one done pulse a fixed time after each start
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dcnt_q <= 0;
            op_done_o <= 1'b0;
        end else begin
            if (start_i) begin
                dcnt_q <= DONE_DLY;
            end else if (dcnt_q > 0) begin
                dcnt_q <= dcnt_q - 1;
            end
            op_done_o <= (dcnt_q == 1) && !start_i;
        end
    end
endmodule // tss_trig_src_model
